// ===== sync_serial_port_map.svh
// Numeric constants of the synchronous serial port
`ifndef SYNC_SERIAL_PORT_MAP_SVH
`define SYNC_SERIAL_PORT_MAP_SVH
// Word length codes hold length minus one
`define SSP_WL_MIN      5'h02
`define SSP_WL_MIN_PAIR 5'h07
// Core clock period and fastest serial bit period
`define SSP_CORE_NS     25
`define SSP_MIN_BIT_NS  20
// Line count and linear sample sign position
`define SSP_LINES       2
`define SSP_LIN_SIGN    15
// Mu-law constants
`define SSP_MU_BIAS     16'h0084
`define SSP_MU_BIAS14   14'h0021
`define SSP_MU_CLIP     14'h1fde
`define SSP_MU_EXP_LO   6
`define SSP_MU_EXP_HI   12
`define SSP_MU_EXP_OFS  5
// A-law constants
`define SSP_A_XOR       8'h55
`define SSP_A_RND       16'h0008
`define SSP_A_SEG       16'h0108
`define SSP_A_CLIP      13'h0fff
`define SSP_A_EXP_LO    5
`define SSP_A_EXP_HI    11
`define SSP_A_EXP_OFS   4
`endif

// ===== ssp_pkg.sv
// Types shared by the synchronous serial port
package ssp_pkg;
  // Framing modes
  typedef enum logic [1:0] {
    MODE_STD = 2'h0,
    MODE_TDM = 2'h1,
    MODE_I2S = 2'h2,
    MODE_LJ  = 2'h3
  } mode_e;
  // Companding per line
  typedef enum logic [1:0] {
    COMP_NONE = 2'h0,
    COMP_MU   = 2'h1,
    COMP_A    = 2'h2
  } comp_e;
  // Settings carried into the link domain
  typedef struct packed {
    logic       en;
    mode_e      mode;
    logic [4:0] wl;
    logic       msb;
    logic [6:0] nwm1;
    logic [1:0] dir;
    logic       fs_int;
  } cfg_s;
endpackage : ssp_pkg

// ===== sync_serial_port.sv
// Synchronous audio serial port with line FIFOs and crossings
`timescale 1ns/1ps
`include "sync_serial_port_map.svh"

// Three-stage synchroniser; output follows once stages two and three agree
module ssp_sync3 #(
  parameter int W = 1
) (
  input  wire logic         i_clk,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);
  logic [W-1:0] s1_ff;   // Only read by s2_ff
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;
  logic [W-1:0] q_ff;    // Filtered value
  // No reset: settles while the reset is held
  always_ff @(posedge i_clk) begin
    s1_ff <= i_d;
    s2_ff <= s1_ff;
    s3_ff <= s2_ff;
    if (s2_ff == s3_ff) begin
      q_ff <= s3_ff;
    end
  end
  assign o_q = q_ff;
endmodule : ssp_sync3

// Word FIFO, depth a power of two
module ssp_fifo #(
  parameter int DW    = 32,
  parameter int DEPTH = 16
) (
  input  wire logic          i_clk,
  input  wire logic          i_rst,
  input  wire logic          i_wr_valid,
  output logic               o_wr_ready,
  input  wire logic [DW-1:0] i_wr_data,
  output logic               o_rd_valid,
  input  wire logic          i_rd_ready,
  output logic      [DW-1:0] o_rd_data
);
  localparam int AW = $clog2(DEPTH);
  logic [DW-1:0] mem [DEPTH];   // Storage
  logic [AW:0]   wp_ff;         // Write pointer with wrap bit
  logic [AW:0]   rp_ff;         // Read pointer with wrap bit
  wire           full  = (wp_ff[AW] != rp_ff[AW])
                       & (wp_ff[AW-1:0] == rp_ff[AW-1:0]);
  wire           empty = wp_ff == rp_ff;
  wire           we    = i_wr_valid & ~full;
  wire           re    = i_rd_ready & ~empty;
  assign o_wr_ready = ~full;
  assign o_rd_valid = ~empty;
  assign o_rd_data  = mem[rp_ff[AW-1:0]];
  // Pointers
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wp_ff <= '0;
      rp_ff <= '0;
    end else begin
      wp_ff <= wp_ff + {{AW{1'b0}}, we};
      rp_ff <= rp_ff + {{AW{1'b0}}, re};
    end
  end
  // Storage write
  always_ff @(posedge i_clk) begin
    if (we) begin
      mem[wp_ff[AW-1:0]] <= i_wr_data;
    end
  end
endmodule : ssp_fifo

// Behaviour
// - Each line transmits or receives, own channel
// - Two lines share one clock, frame sync
// - Standard, TDM, I2S, left-justified modes
// - TDM frames carry up to 128 slots
// - Left-justified: one sample per sync level
// - Two ports pair: all-tx and all-rx
// - Pair modes carry four channels per port
// - Word shifts MSB first or LSB first
// - Standard and TDM words 3 to 32 bits
// - Pair mode words 8 to 32 bits
// - Mu-law or A-law per line
// - Clock and sync internal or external
// - Bit rate up to 50 Mbit/s; internal clock at most 20 Mbit/s
module sync_serial_port #(
  parameter int DW        = 32,
  parameter int DEPTH     = 16,
  parameter int SCLK_HALF = (`SSP_MIN_BIT_NS + 2 * `SSP_CORE_NS - 1)
                            / (2 * `SSP_CORE_NS)
) (
  input  wire logic                  I_CORE_CLK,
  input  wire logic                  I_SRST,
  input  wire logic                  I_LINK_CLK,
  input  wire logic                  I_EN,
  input  wire logic [1:0]            I_MODE,
  input  wire logic [4:0]            I_WLEN,
  input  wire logic                  I_MSB_FIRST,
  input  wire logic [6:0]            I_SLOTS,
  input  wire logic [1:0]            I_DIR_TX,
  input  wire logic                  I_CLK_INT,
  input  wire logic                  I_FS_INT,
  input  wire logic [3:0]            I_COMP,
  input  wire logic [2*DW-1:0]       I_TX_DATA,
  input  wire logic [1:0]            I_TX_VALID,
  output logic      [1:0]            O_TX_READY,
  output logic      [2*DW-1:0]       O_RX_DATA,
  output logic      [1:0]            O_RX_VALID,
  input  wire logic [1:0]            I_RX_READY,
  output logic                       O_SCLK,
  output logic                       O_SCLK_OE_N,
  input  wire logic                  I_FS,
  output logic                       O_FS,
  output logic                       O_FS_OE_N,
  input  wire logic [1:0]            I_DATA,
  output logic      [1:0]            O_DATA,
  output logic      [1:0]            O_DATA_OE_N
);
  // Mu-law compression of a 16-bit linear sample
  function automatic logic [7:0] mu_enc(input logic [15:0] x);
    logic [15:0] a;
    logic [13:0] m;
    logic [2:0]  e;
    logic [3:0]  t;
    a = x[`SSP_LIN_SIGN] ? 16'(-x) : x;
    m = a[15:2];
    if (m > `SSP_MU_CLIP) m = `SSP_MU_CLIP;
    m = m + `SSP_MU_BIAS14;
    e = '0;
    for (int k = `SSP_MU_EXP_LO; k <= `SSP_MU_EXP_HI; k++) begin
      if (m[k]) e = 3'(k - `SSP_MU_EXP_OFS);
    end
    t = 4'(m >> ({1'b0, e} + 4'h1));
    return ~{x[`SSP_LIN_SIGN], e, t};
  endfunction : mu_enc

  // Mu-law expansion to 16-bit linear
  function automatic logic [15:0] mu_dec(input logic [7:0] c);
    logic [7:0]  v;
    logic [15:0] m;
    v = ~c;
    m = 16'((16'({v[3:0], 3'h0}) + `SSP_MU_BIAS) << v[6:4]);
    m = m - `SSP_MU_BIAS;
    return v[7] ? 16'(-m) : m;
  endfunction : mu_dec

  // A-law compression of a 16-bit linear sample
  function automatic logic [7:0] a_enc(input logic [15:0] x);
    logic [15:0] a;
    logic [12:0] m;
    logic [2:0]  e;
    logic [3:0]  t;
    a = x[`SSP_LIN_SIGN] ? 16'(-x) : x;
    m = a[15:3];
    if (m > `SSP_A_CLIP) m = `SSP_A_CLIP;
    e = '0;
    for (int k = `SSP_A_EXP_LO; k <= `SSP_A_EXP_HI; k++) begin
      if (m[k]) e = 3'(k - `SSP_A_EXP_OFS);
    end
    t = (e == 3'h0) ? m[4:1] : 4'(m >> e);
    return {~x[`SSP_LIN_SIGN], e, t} ^ `SSP_A_XOR;
  endfunction : a_enc

  // A-law expansion to 16-bit linear
  function automatic logic [15:0] a_dec(input logic [7:0] c);
    logic [7:0]  v;
    logic [15:0] t;
    logic [15:0] m;
    v = c ^ `SSP_A_XOR;
    t = 16'({v[3:0], 4'h0});
    m = (v[6:4] == 3'h0) ? t + `SSP_A_RND
                         : 16'((t + `SSP_A_SEG) << (v[6:4] - 3'h1));
    return v[7] ? m : 16'(-m);
  endfunction : a_dec

  // ---------------- Core domain settings ----------------
  ssp_pkg::cfg_s cfg_ff;        // Settings registered in core domain
  ssp_pkg::cfg_s nxt_cfg;
  ssp_pkg::cfg_s lc;            // Settings seen by the link domain
  wire pair_c = (I_MODE == ssp_pkg::MODE_I2S)
              | (I_MODE == ssp_pkg::MODE_LJ);
  wire [4:0] wl_lo = pair_c ? `SSP_WL_MIN_PAIR : `SSP_WL_MIN;
  // Short words are raised to the legal floor of the mode
  wire [4:0] wl_c = (I_WLEN < wl_lo) ? wl_lo : I_WLEN;
  // One word per frame, a slot count, or a sample pair
  wire [6:0] nw_c = (I_MODE == ssp_pkg::MODE_TDM) ? I_SLOTS
                  : {6'h00, pair_c};
  assign nxt_cfg = '{en: I_EN, mode: ssp_pkg::mode_e'(I_MODE),
                     wl: wl_c, msb: I_MSB_FIRST, nwm1: nw_c,
                     dir: I_DIR_TX, fs_int: I_FS_INT};
  // Settings register; quasi-static, change only while disabled
  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) cfg_ff <= '0;
    else        cfg_ff <= nxt_cfg;
  end
  // Settings flop still holds its reset zeros one edge after release
  wlen_floor_a: assert property (@(posedge I_CORE_CLK)
    disable iff (I_SRST)
    !$past(I_SRST) |->
    cfg_ff.wl >= ((cfg_ff.mode == ssp_pkg::MODE_I2S ||
                   cfg_ff.mode == ssp_pkg::MODE_LJ) ? `SSP_WL_MIN_PAIR
                                                     : `SSP_WL_MIN))
    else $error("word length below mode floor");

  // Internal serial clock divider; period bounded by the bit rate
  logic [7:0] div_ff;           // Half-period counter
  logic       sclk_ff;          // Generated serial clock
  wire        div_end = div_ff == 8'(SCLK_HALF - 1);
  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST | ~I_CLK_INT) begin
      div_ff  <= '0;
      sclk_ff <= 1'b0;
    end else begin
      div_ff  <= div_end ? 8'h00 : div_ff + 8'h01;
      sclk_ff <= sclk_ff ^ div_end;
    end
  end
  assign O_SCLK      = sclk_ff;
  assign O_SCLK_OE_N = ~I_CLK_INT;
  sclk_half_a: assert property (@(posedge I_CORE_CLK)
    disable iff (I_SRST)
    I_CLK_INT && $past(I_CLK_INT) && $changed(sclk_ff)
      |-> $past(div_ff) == 8'(SCLK_HALF - 1))
    else $error("serial clock half period wrong");

  // ---------------- Link domain framing ----------------
  logic link_rst;               // Reset seen on the link clock
  ssp_sync3 #(.W(1)) u_lrst (
    .i_clk (I_LINK_CLK),
    .i_d   (I_SRST),
    .o_q   (link_rst)
  );
  ssp_sync3 #(.W($bits(ssp_pkg::cfg_s))) u_lcfg (
    .i_clk (I_LINK_CLK),
    .i_d   (cfg_ff),
    .o_q   (lc)
  );
  logic [4:0] bit_ff;           // Bit position in the current word
  logic [6:0] slot_ff;          // Word slot in the current frame
  logic       fs_prev_ff;       // Last sampled external frame sync
  logic       fs_out_ff;        // Generated frame sync
  wire pair_l = (lc.mode == ssp_pkg::MODE_I2S)
              | (lc.mode == ssp_pkg::MODE_LJ);
  wire is_lj  = lc.mode == ssp_pkg::MODE_LJ;
  wire last_bit  = bit_ff == lc.wl;
  wire last_slot = slot_ff >= lc.nwm1;
  wire [4:0] step_bit  = last_bit ? 5'h00 : bit_ff + 5'h01;
  wire [6:0] step_slot = ~last_bit ? slot_ff
                       : last_slot ? 7'h00 : slot_ff + 7'h01;
  // External sync realigns: a pulse before the word, or a level edge
  wire ext    = ~lc.fs_int;
  wire rsync  = ext & (pair_l ? (I_FS != fs_prev_ff) : I_FS);
  // Left-justified edge marks bit zero, already in flight
  wire [4:0] nxt_bit  = rsync ? {4'h0, is_lj} : step_bit;
  wire [6:0] nxt_slot = ~rsync ? step_slot
                      : pair_l ? {6'h00, I_FS ^ is_lj}
                      : 7'h00;
  wire nl_bit  = nxt_bit == lc.wl;
  wire nl_slot = nxt_slot >= lc.nwm1;
  // Generated sync for the coming cycle, by mode
  wire fs_std = nl_bit & nl_slot;
  wire fs_i2s = nl_bit ? (nxt_slot == 7'h00)
                       : (nxt_slot != 7'h00);
  wire fs_lj  = nxt_slot == 7'h00;
  wire nxt_fs = lc.en & (~pair_l ? fs_std : is_lj ? fs_lj : fs_i2s);
  // Idle position is the frame end, so the first word starts clean
  always_ff @(posedge I_LINK_CLK) begin
    if (link_rst) begin
      bit_ff     <= '0;
      slot_ff    <= '0;
      fs_prev_ff <= 1'b0;
      fs_out_ff  <= 1'b0;
    end else if (~lc.en) begin
      bit_ff     <= lc.wl;
      slot_ff    <= lc.nwm1;
      fs_prev_ff <= I_FS;
      fs_out_ff  <= 1'b0;
    end else begin
      bit_ff     <= nxt_bit;
      slot_ff    <= nxt_slot;
      fs_prev_ff <= I_FS;
      fs_out_ff  <= nxt_fs;
    end
  end
  assign O_FS      = fs_out_ff;
  assign O_FS_OE_N = ~lc.fs_int;

  // One frame sync and one clock serve both lines
  sequence std_sync_s;
    lc.fs_int && lc.en && !pair_l && fs_out_ff;
  endsequence
  sequence frame_top_s;
    bit_ff == 5'h00 && slot_ff == 7'h00;
  endsequence
  fs_std_a: assert property (@(posedge I_LINK_CLK)
    disable iff (link_rst)
    std_sync_s ##1 lc.en |-> frame_top_s)
    else $error("standard sync not one clock before slot 0");
  sequence i2s_fall_s;
    lc.fs_int && lc.en && lc.mode == ssp_pkg::MODE_I2S
      && $fell(fs_out_ff);
  endsequence
  i2s_msb_a: assert property (@(posedge I_LINK_CLK)
    disable iff (link_rst)
    i2s_fall_s ##1 lc.en |-> frame_top_s ##1 !fs_out_ff)
    else $error("I2S left word not one clock after fall");
  lj_level_a: assert property (@(posedge I_LINK_CLK)
    disable iff (link_rst)
    lc.fs_int && lc.en && is_lj && $past(lc.en)
      |-> fs_out_ff == (slot_ff == 7'h00) && slot_ff <= 7'h01)
    else $error("left-justified sync level mismatch");
  slot_max_a: assert property (@(posedge I_LINK_CLK)
    disable iff (link_rst)
    lc.en && $stable(lc) && $past(lc.en) |-> slot_ff <= lc.nwm1)
    else $error("slot counter past frame length");

  // Bit index inside a word for either shift order
  wire [4:0] tx_idx = lc.msb ? lc.wl - nxt_bit : nxt_bit;
  wire [4:0] rx_idx = lc.msb ? lc.wl - bit_ff : bit_ff;

  // ---------------- Per line: link, crossing, FIFO ----------------
  logic [1:0]    ct_ff;              // Core-side toggle per line
  logic [1:0]    lt_ff;              // Link-side toggle per line
  logic [DW-1:0] core_word [2];      // Word offered to the link
  logic [DW-1:0] link_word [2];      // Word received from the link
  logic [1:0]    dout_ff;            // Serial data out

  for (genvar j = 0; j < `SSP_LINES; j++) begin : g_line
    logic          ct_s;             // Core toggle in link domain
    logic          lt_s;             // Link toggle in core domain
    logic [DW-1:0] sh_ff;            // Shift word
    logic          tx_rdy;           // Hold register empty
    logic          fifo_wr_rdy;
    logic          fifo_rd_val;
    logic [DW-1:0] fifo_rd;
    wire           dir_l = lc.dir[j];
    wire           dir_c = cfg_ff.dir[j];
    wire [1:0]     comp  = I_COMP[2*j +: 2];
    ssp_sync3 #(.W(1)) u_ct (
      .i_clk (I_LINK_CLK),
      .i_d   (ct_ff[j]),
      .o_q   (ct_s)
    );
    ssp_sync3 #(.W(1)) u_lt (
      .i_clk (I_CORE_CLK),
      .i_d   (lt_ff[j]),
      .o_q   (lt_s)
    );
    // Link: take an offered word at word start, else send zeros
    wire take = lc.en & dir_l & (nxt_bit == 5'h00) & (ct_s != lt_ff[j]);
    wire [DW-1:0] src = (nxt_bit != 5'h00) ? sh_ff
                      : take ? core_word[j] : '0;
    wire [DW-1:0] rx_base = (bit_ff == 5'h00) ? '0 : sh_ff;
    wire [DW-1:0] rx_nxt  = rx_base | (DW'(I_DATA[j]) << rx_idx);
    wire          rx_done = lc.en & ~dir_l & last_bit;
    // Shift path per line direction
    always_ff @(posedge I_LINK_CLK) begin
      if (link_rst) begin
        sh_ff        <= '0;
        dout_ff[j]   <= 1'b0;
        lt_ff[j]     <= 1'b0;
        link_word[j] <= '0;
      end else begin
        sh_ff        <= dir_l ? src : rx_nxt;
        dout_ff[j]   <= lc.en & dir_l & src[tx_idx];
        lt_ff[j]     <= lt_ff[j] ^ (take | rx_done);
        link_word[j] <= rx_done ? rx_nxt : link_word[j];
      end
    end
    assign O_DATA[j]      = dout_ff[j];
    // A receiving line leaves its pin to the partner
    assign O_DATA_OE_N[j] = ~dir_l;
    bit_order_a: assert property (@(posedge I_LINK_CLK)
      disable iff (link_rst)
      lc.en && dir_l && $stable(lc) && bit_ff == 5'h00 |->
        dout_ff[j] == (lc.msb ? sh_ff[lc.wl] : sh_ff[0]))
      else $error("first bit of word in wrong order");
    rx_push_a: assert property (@(posedge I_LINK_CLK)
      disable iff (link_rst)
      rx_done |=> $changed(lt_ff[j]) && !dout_ff[j])
      else $error("received word not handed over");

    // Core: one FIFO per line, filled by user or link
    wire rx_push = ~dir_c & (lt_s != ct_ff[j]);
    wire [15:0] lin = (comp == ssp_pkg::COMP_MU) ? mu_dec(link_word[j][7:0])
                                                  : a_dec(link_word[j][7:0]);
    wire [DW-1:0] rx_word = (comp == ssp_pkg::COMP_NONE) ? link_word[j]
                          : {{(DW-16){lin[15]}}, lin};
    assign tx_rdy = lt_s == ct_ff[j];
    wire tx_load = dir_c & fifo_rd_val & tx_rdy;
    wire [7:0] cw = (comp == ssp_pkg::COMP_MU) ? mu_enc(fifo_rd[15:0])
                                               : a_enc(fifo_rd[15:0]);
    wire [DW-1:0] tx_word = (comp == ssp_pkg::COMP_NONE) ? fifo_rd
                          : {{(DW-8){1'b0}}, cw};
    ssp_fifo #(.DW(DW), .DEPTH(DEPTH)) u_fifo (
      .i_clk      (I_CORE_CLK),
      .i_rst      (I_SRST),
      .i_wr_valid (dir_c ? I_TX_VALID[j] : rx_push),
      .o_wr_ready (fifo_wr_rdy),
      .i_wr_data  (dir_c ? I_TX_DATA[DW*j +: DW] : rx_word),
      .o_rd_valid (fifo_rd_val),
      .i_rd_ready (dir_c ? tx_rdy : I_RX_READY[j]),
      .o_rd_data  (fifo_rd)
    );
    // Hand-over toggle; a full receive FIFO drops the word
    always_ff @(posedge I_CORE_CLK) begin
      if (I_SRST) begin
        ct_ff[j]     <= 1'b0;
        core_word[j] <= '0;
      end else begin
        ct_ff[j]     <= ct_ff[j] ^ (tx_load | rx_push);
        core_word[j] <= tx_load ? tx_word : core_word[j];
      end
    end
    assign O_TX_READY[j]           = dir_c & fifo_wr_rdy;
    assign O_RX_VALID[j]           = ~dir_c & fifo_rd_val;
    assign O_RX_DATA[DW*j +: DW]   = fifo_rd;
    tx_hold_a: assert property (@(posedge I_CORE_CLK)
      disable iff (I_SRST)
      tx_load |=> !tx_rdy [*3])
      else $error("offered word released too early");
  end
endmodule : sync_serial_port

// ===== ssp_codec_model.sv
// Behavioural codec at the far side of the serial port
`timescale 1ns/1ps
module ssp_codec_model (
  input  wire logic       i_sclk,   // Serial clock wire
  input  wire logic       i_fs_pin, // Frame sync wire
  input  wire logic [4:0] i_wl,     // Word length minus one
  input  wire logic       i_msb,    // Bit order
  input  wire logic       i_dout,   // Line 0 wire
  output logic            o_fs,     // Sync when the codec makes it
  output logic            o_din,    // Echo into line 1
  output logic            o_idle    // Undriven line, never holds
);
  logic [31:0] word;                // Word being gathered
  logic [31:0] cap_q[$];            // Words seen on line 0
  int          cnt = 0;             // Bit position in the word
  int          fcnt = 0;            // Own sync divider
  int          per = 0;             // Running frame length
  int          hi = 0;              // Running sync high time
  int          fs_per = 0;          // Last whole frame length
  int          fs_hi = 0;           // Last whole sync high time
  logic        fs_d = 1'b0;         // Sync at the previous edge
  initial begin
    o_fs = 1'b0;
    o_din = 1'b0;
    o_idle = 1'b0;
    word = '0;
  end
  // Drive on the falling edge so the port sees settled levels
  always @(negedge i_sclk) begin
    o_din  <= i_dout;
    o_idle <= ~o_idle;
    fcnt   <= (fcnt >= i_wl) ? 0 : fcnt + 1;
    o_fs   <= (fcnt == i_wl - 1);
    // Sync rides on the last bit before a word; idle zeros are skipped
    if (cnt <= i_wl) begin
      word[i_msb ? i_wl - cnt : cnt] = i_dout;
      if (cnt == i_wl && word != '0) cap_q.push_back(word);
      cnt++;
    end
    // Restart the count after the bit that the sync cycle carries
    if (i_fs_pin) begin
      cnt = 0;
      word = '0;
    end
  end
  // Frame figures taken at the port's sampling edge
  always @(posedge i_sclk) begin
    if (i_fs_pin && !fs_d) begin
      fs_per = per;
      per = 0;
      hi = 0;
    end
    if (!i_fs_pin && fs_d) fs_hi = hi;
    per++;
    if (i_fs_pin) hi++;
    fs_d = i_fs_pin;
  end
endmodule : ssp_codec_model

// ===== test_sync_serial_port.sv
// Self-checking bench for the synchronous serial port
`timescale 1ns/1ps
module test_sync_serial_port;
  logic        core_clk, link_gen, srst, en, msb, clk_int, fs_int;
  logic [1:0]  mode, dir_tx, tx_valid, rx_ready, tx_ready, rx_valid;
  logic [4:0]  wlen, wl_eff;
  logic [6:0]  slots;
  logic [3:0]  comp;
  logic [63:0] tx_data, rx_data;
  logic        sclk, sclk_oe_n, fs_o, fs_oe_n, cfs, crx, cidle;
  logic [1:0]  d_o, d_oe_n, d_pin;
  logic [31:0] seed = 32'h4285fa7d;    // Fixed seed, repeatable run
  logic [31:0] exp_q[$];               // Words due at the receiver
  logic [4:0]  w_t[4] = '{5'h00, 5'h05, 5'h03, 5'h1f}; // Corner lengths
  int          err_count = 0;
  int          num_checks = 0;
  // Wire levels worked out from every driver's enable
  wire link_clk = sclk_oe_n ? link_gen : sclk;
  wire fs_pin = fs_oe_n ? cfs : fs_o;
  assign d_pin[0] = d_oe_n[0] ? cidle : d_o[0];
  assign d_pin[1] = d_oe_n[1] ? crx : d_o[1];
  assign wl_eff = 5'(eff_wl(mode, wlen));

  sync_serial_port #(.DW(32), .DEPTH(16), .SCLK_HALF(1)) uut (
    .I_CORE_CLK(core_clk), .I_SRST(srst), .I_LINK_CLK(link_clk),
    .I_EN(en), .I_MODE(mode), .I_WLEN(wlen), .I_MSB_FIRST(msb),
    .I_SLOTS(slots), .I_DIR_TX(dir_tx), .I_CLK_INT(clk_int),
    .I_FS_INT(fs_int), .I_COMP(comp), .I_TX_DATA(tx_data),
    .I_TX_VALID(tx_valid), .O_TX_READY(tx_ready), .O_RX_DATA(rx_data),
    .O_RX_VALID(rx_valid), .I_RX_READY(rx_ready), .O_SCLK(sclk),
    .O_SCLK_OE_N(sclk_oe_n), .I_FS(fs_pin), .O_FS(fs_o),
    .O_FS_OE_N(fs_oe_n), .I_DATA(d_pin), .O_DATA(d_o),
    .O_DATA_OE_N(d_oe_n));
  ssp_codec_model codec (
    .i_sclk(link_clk), .i_fs_pin(fs_pin), .i_wl(wl_eff), .i_msb(msb),
    .i_dout(d_pin[0]), .o_fs(cfs), .o_din(crx), .o_idle(cidle));

  // Xorshift source of all random stimulus
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  // Length code after the port raises a too-short request
  function automatic int eff_wl(input logic [1:0] m, input logic [4:0] w);
    int lo = (m >= 2'h2) ? 7 : 2;
    return (w < lo) ? lo : int'(w);
  endfunction : eff_wl
  // One compare, counted; mismatches reported at once
  task check(input logic [63:0] seen, input logic [63:0] expv);
    num_checks++;
    if (seen !== expv) begin
      err_count++;
      $display("FAIL %0t seen %h expected %h", $time, seen, expv);
    end
  endtask : check
  task results();
    if (err_count == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : results
  // Settings change only while disabled, with time to cross over
  task setup(input logic [1:0] m, input logic [4:0] w, input logic [6:0] s,
             input logic ci, input logic fi, input logic [1:0] c);
    @(posedge core_clk) en <= 1'b0;
    repeat (30) @(posedge core_clk);
    mode <= m;
    wlen <= w;
    slots <= s;
    clk_int <= ci;
    fs_int <= fi;
    comp <= {2'h0, c};
    msb <= xs() % 2 == 0;
    repeat (30) @(posedge core_clk);
    en <= 1'b1;
    // Let the link lock its framing before any data flows
    repeat (40) @(posedge core_clk);
  endtask : setup
  // Line 0 sends, echo returns on line 1; zero words are idle fill
  task run_data(input int n, input logic [31:0] cz);
    logic [31:0] w, mask, got, expw;
    logic [31:0] sent[$];
    int          acc, t, full_at;
    mask = (wl_eff == 5'h1f) ? 32'hffffffff : (32'h1 << (wl_eff + 1)) - 1;
    acc = 0;
    t = 0;
    full_at = 0;
    exp_q.delete();
    sent.delete();
    codec.cap_q.delete();
    w = (cz != 0) ? 32'h0 : (xs() | 32'h1);
    @(posedge core_clk);
    tx_valid <= 2'b01;
    tx_data[31:0] <= w;
    while ((acc < n || exp_q.size() > 0) && t < 30000) begin
      @(posedge core_clk);
      t++;
      if (tx_valid[0] && tx_ready[0]) begin
        sent.push_back(w & mask);
        exp_q.push_back((cz != 0) ? cz : (w & mask));
        acc++;
        w = (cz != 0) ? 32'h0 : (xs() | 32'h1);
        tx_data[31:0] <= w;
      end else if (tx_valid[0] && full_at == 0) full_at = acc;
      tx_valid[0] <= (acc < n);
      if (rx_valid[1] && rx_ready[1]) begin
        got = rx_data[63:32];
        // A word nobody sent is held against zero and fails
        if (got != 0) begin
          expw = (exp_q.size() > 0) ? exp_q.pop_front() : 32'h0;
          check(got, expw);
        end
      end
      rx_ready <= {xs() % 2 == 0, 1'b0};
    end
    check(t < 30000, 1'b1);
    if (n > 1) check(full_at >= 16 && full_at <= 19, 1'b1);
    // Wire order of bits seen by the codec itself
    if (mode == 2'h0 && fs_int && cz == 0) begin
      check(codec.cap_q.size(), sent.size());
      foreach (sent[i]) check(codec.cap_q[i], sent[i]);
    end
  endtask : run_data
  // Frame length and sync shape for the current settings
  task frame_chk();
    int words;
    words = (mode == 2'h1) ? slots + 1 : (mode >= 2'h2) ? 2 : 1;
    check(codec.fs_per, words * (wl_eff + 1));
    check(codec.fs_hi, (mode >= 2'h2) ? wl_eff + 1 : 1);
    check(d_oe_n, 2'b10);
    check({tx_ready[1], rx_valid[0]}, 2'b00);
  endtask : frame_chk

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  // Link clock in its own phase
  initial begin
    link_gen = 1'b0;
    #7;
    forever #32 link_gen = ~link_gen;
  end
  // Cut a hang short
  initial begin
    repeat (80000) @(posedge core_clk);
    err_count++;
    results();
  end
  initial begin
    srst = 1'b1;
    en = 1'b0;
    mode = 2'h0;
    wlen = 5'h07;
    msb = 1'b1;
    slots = 7'h00;
    dir_tx = 2'b01;
    clk_int = 1'b0;
    fs_int = 1'b1;
    comp = 4'h0;
    tx_data = '0;
    tx_valid = 2'b00;
    rx_ready = 2'b00;
    // Longer than three cycles so both domains see the reset
    repeat (24) @(posedge core_clk);
    check({sclk, fs_o, d_o, tx_ready, rx_valid}, 8'h00);
    srst <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      setup(2'(i % 4), (i < 4) ? w_t[i] : 5'(xs() % 30 + 2),
            7'(xs() % 8), 1'b0, 1'b1, 2'h0);
      run_data(20, 32'h0);
      frame_chk();
    end
    setup(2'h1, 5'h02, 7'h7f, 1'b0, 1'b1, 2'h0);
    repeat (3000) @(posedge core_clk);
    frame_chk();
    // Codes of a linear zero for both companding laws
    setup(2'h0, 5'h07, 7'h00, 1'b0, 1'b1, 2'h1);
    run_data(1, 32'hff);
    setup(2'h0, 5'h07, 7'h00, 1'b0, 1'b1, 2'h2);
    run_data(1, 32'hd5);
    // Port makes the clock, the codec makes the sync
    setup(2'h0, 5'h07, 7'h00, 1'b1, 1'b0, 2'h0);
    run_data(20, 32'h0);
    check({sclk_oe_n, fs_oe_n}, 2'b01);
    results();
  end
endmodule : test_sync_serial_port
